// ===== rtl/esa_config.sv
// Purpose: derives slave address, framing and indicator drive from switches and stored variables
// Assumes: var_wr/var_rd are one-cycle strobes from the protocol engine, which has already matched the frame
// Notes:   rstn models a blank nonvolatile image; restart keeps the stored variables unless it enters programming
`timescale 1ns/1ps
module esa_config #(
  parameter int FLASH_CYC = esa_pkg::FLASH_HALF_CYC,
  parameter int ACT_CYC   = esa_pkg::ACT_HOLD_CYC
) (
  input  wire logic                   mclk,
  input  wire logic                   rstn,
  input  wire esa_pkg::esa_sw_t       sw,
  input  wire logic                   restart,
  input  wire logic                   traffic,
  input  wire logic                   var_wr,
  input  wire logic                   var_rd,
  input  wire logic [15:0]            var_index,
  input  wire logic [15:0]            var_wdata,
  output logic [15:0]                 var_rdata,
  output logic                        var_rvalid,
  output esa_pkg::esa_line_cfg_t      line_cfg,
  output logic                        online,
  output logic                        prog_mode,
  output logic                        led_green,
  output logic                        led_yellow
);
  import esa_pkg::*;

  esa_state_t s_r;
  esa_state_t s_nxt;

  // =====================================================================
  // helpers
  function automatic logic [2:0] fmt_decode(input logic [15:0] f);
    case (f[2:0])
      3'h1:    fmt_decode = {PAR_NONE, 1'b0};
      3'h2:    fmt_decode = {PAR_ODD, 1'b1};
      3'h3:    fmt_decode = {PAR_ODD, 1'b0};
      3'h4:    fmt_decode = {PAR_EVEN, 1'b1};
      3'h5:    fmt_decode = {PAR_EVEN, 1'b0};
      default: fmt_decode = {PAR_NONE, 1'b1};
    endcase
  endfunction

  function automatic logic [15:0] offset_limit(input logic vendor);
    offset_limit = vendor ? OFFSET_MAX_VENDOR : OFFSET_MAX_MODBUS;
  endfunction

  logic [7:0] sum_addr;
  logic [7:0] addr_max;
  assign sum_addr = s_r.offset[7:0] + {4'h0, s_r.sw.addr};
  assign addr_max = s_r.sw.vendor_prot ? ADDR_MAX_VENDOR : ADDR_MAX_MODBUS;

  // =====================================================================
  // next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.rvalid = 1'b0;

    // switches only enter the design here, on restart
    if (restart) begin
      s_nxt.sw   = sw;
      s_nxt.mode = MODE_BOOT;
      // off the line while switches are re-evaluated
      s_nxt.online = 1'b0;
    end

    case (s_r.mode)
      MODE_BOOT: begin
        s_nxt.cfg.baud        = s_r.sw.baud;
        s_nxt.cfg.vendor_prot = s_r.sw.vendor_prot;
        {s_nxt.cfg.parity, s_nxt.cfg.two_stop} = fmt_decode(s_r.format);
        s_nxt.online = 1'b0;
        s_nxt.prog   = 1'b0;
        // programming entered: extension off with no address on the switches
        if (!s_r.sw.ext && s_r.sw.addr == ADDR_SW_OFF) begin
          s_nxt.mode   = MODE_PROG;
          s_nxt.prog   = 1'b1;
          s_nxt.offset = OFFSET_RESET;
          s_nxt.format = FORMAT_RESET;
          s_nxt.cfg.slave_addr = ADDR_PROG;
          {s_nxt.cfg.parity, s_nxt.cfg.two_stop} = {PAR_NONE, 1'b1};
          s_nxt.online = 1'b1;
        end else if (!s_r.sw.ext) begin
          s_nxt.mode = MODE_NORMAL;
          s_nxt.cfg.slave_addr = {4'h0, s_r.sw.addr};
          s_nxt.online = 1'b1;
        end else if (s_r.offset == OFFSET_RESET) begin
          s_nxt.mode = MODE_ERR_STEADY;
        end else if (s_r.sw.addr == ADDR_SW_OFF) begin
          s_nxt.mode = MODE_ERR_FLASH;
        end else if (sum_addr < ADDR_EXT_MIN || sum_addr > addr_max) begin
          // offset stored under the other protocol no longer fits
          s_nxt.mode = MODE_ERR_STEADY;
        end else begin
          s_nxt.mode = MODE_NORMAL;
          s_nxt.cfg.slave_addr = sum_addr;
          s_nxt.online = 1'b1;
        end
      end
      MODE_NORMAL, MODE_PROG, MODE_ERR_STEADY, MODE_ERR_FLASH: begin
      end
      default: s_nxt.mode = MODE_BOOT;
    endcase

    // stored variables: take effect at the next restart only
    if (var_wr && s_r.online && s_r.mode != MODE_BOOT) begin
      if (var_index == VAR_IDX_OFFSET && var_wdata > OFFSET_MIN_EXCL &&
          var_wdata <= offset_limit(s_r.cfg.vendor_prot)) begin
        s_nxt.offset = var_wdata;
      end
      if (var_index == VAR_IDX_FORMAT && var_wdata <= FORMAT_MAX) begin
        s_nxt.format = var_wdata;
      end
    end
    if (var_rd) begin
      s_nxt.rvalid = 1'b1;
      if (var_index == VAR_IDX_OFFSET) begin
        s_nxt.rdata = s_r.offset;
      end else if (var_index == VAR_IDX_FORMAT) begin
        s_nxt.rdata = s_r.format;
      end else begin
        s_nxt.rdata = 16'h0000;
      end
    end

    // shared flash timebase
    if (s_r.flash_cnt >= 25'(FLASH_CYC - 1)) begin
      s_nxt.flash_cnt = 25'h0000000;
      s_nxt.flash_ph  = ~s_r.flash_ph;
    end else begin
      s_nxt.flash_cnt = s_r.flash_cnt + 25'h0000001;
    end

    // traffic seen recently keeps the port marked active
    if (traffic && s_r.online) begin
      s_nxt.act_cnt = 25'(ACT_CYC - 1);
    end else if (s_r.act_cnt != 25'h0000000) begin
      s_nxt.act_cnt = s_r.act_cnt - 25'h0000001;
    end
    if (!s_r.online) begin
      s_nxt.act_cnt = 25'h0000000;
    end

    s_nxt.green = (s_r.act_cnt != 25'h0000000) ? s_r.flash_ph : 1'b1;
    case (s_r.mode)
      MODE_PROG:       s_nxt.yellow = s_r.flash_ph;
      MODE_ERR_STEADY: s_nxt.yellow = 1'b1;
      MODE_ERR_FLASH:  s_nxt.yellow = s_r.flash_ph;
      default:         s_nxt.yellow = 1'b0;
    endcase
  end

  // =====================================================================
  // registers; power-on reset enters boot with switches cleared, so programming is entered until a restart
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '{mode: MODE_BOOT, sw: '0, offset: OFFSET_RESET, format: FORMAT_RESET,
               cfg: '{slave_addr: 8'h00, baud: BAUD_19K2, vendor_prot: 1'b0, parity: PAR_NONE, two_stop: 1'b1},
               online: 1'b0, prog: 1'b0, green: 1'b1, yellow: 1'b0, flash_cnt: 25'h0000000,
               flash_ph: 1'b0, act_cnt: 25'h0000000, rdata: 16'h0000, rvalid: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign var_rdata  = s_r.rdata;
  assign var_rvalid = s_r.rvalid;
  assign line_cfg   = s_r.cfg;
  assign online     = s_r.online;
  assign prog_mode  = s_r.prog;
  assign led_green  = s_r.green;
  assign led_yellow = s_r.yellow;

endmodule

// ===== rtl/esa_pkg.sv
// Purpose: constants and types for the expansion-module serial address and line-format configuration
// Assumes: 25 MHz mclk; restart is a one-cycle pulse from the supervisor; switches are static between restarts
// Notes:   stored offset and format live in the nonvolatile image held by esa_config
//
// Notes on behaviour
// - extension switch off gives slave address straight from address switches, 1 to 15.
// - with switches at default the port runs 19.2 Kbps and Modbus.
// - line rate and protocol switches are sampled only at power-up or restart; the code samples them at restart only, rstn loads zeros.
// - switch changes while running take effect only at the next restart.
// - programming state is entered at restart and clears stored offset and format.
// - programming state answers at address 207, 8N2, yellow indicator flashing.
// - format variable at index 17 takes 0 to 5, applied after next restart.
// - offset variable at index 14 must exceed 14; limit 192 vendor, 232 Modbus.
// - extension on with nonzero base gives address offset plus address switches.
// - serial addresses span 16 to 247, or up to 207 under the vendor protocol.
// - green flashes while serial traffic is present, steady on otherwise.
// - extension on with zero offset: steady yellow, offline, green on.
// - extension on, offset set, address switches zero: flashing yellow, offline.
package esa_pkg;

  // =====================================================================
  // variable indices and limits
  localparam logic [15:0] VAR_IDX_OFFSET    = 16'h000e;
  localparam logic [15:0] VAR_IDX_FORMAT    = 16'h0011;
  localparam logic [15:0] OFFSET_MIN_EXCL   = 16'h000e;
  localparam logic [15:0] OFFSET_MAX_VENDOR = 16'h00c0;
  localparam logic [15:0] OFFSET_MAX_MODBUS = 16'h00e8;
  localparam logic [15:0] FORMAT_MAX        = 16'h0005;
  localparam logic [7:0]  ADDR_PROG         = 8'hcf;
  localparam logic [7:0]  ADDR_EXT_MIN      = 8'h10;
  localparam logic [7:0]  ADDR_MAX_MODBUS   = 8'hf7;
  localparam logic [7:0]  ADDR_MAX_VENDOR   = 8'hcf;
  localparam logic [15:0] OFFSET_RESET      = 16'h0000;
  localparam logic [15:0] FORMAT_RESET      = 16'h0000;

  // =====================================================================
  // line encodings; baud code 0 is 19.2 Kbps, protocol 0 is Modbus
  localparam logic [1:0] BAUD_19K2  = 2'h0;
  localparam logic [1:0] PAR_NONE   = 2'h0;
  localparam logic [1:0] PAR_ODD    = 2'h1;
  localparam logic [1:0] PAR_EVEN   = 2'h2;
  localparam logic [3:0] ADDR_SW_OFF = 4'h0;

  // =====================================================================
  // timing
  localparam int CLK_KHZ        = 25000;
  localparam int FLASH_HALF_MS  = 250;
  localparam int ACT_HOLD_MS    = 1000;
  localparam int FLASH_HALF_CYC = FLASH_HALF_MS * CLK_KHZ;
  localparam int ACT_HOLD_CYC   = ACT_HOLD_MS * CLK_KHZ;

  // =====================================================================
  // types
  typedef enum logic [2:0] {
    MODE_BOOT,
    MODE_NORMAL,
    MODE_PROG,
    MODE_ERR_STEADY,
    MODE_ERR_FLASH
  } esa_mode_t;

  typedef struct packed {
    logic       ext;
    logic [3:0] addr;
    logic [1:0] baud;
    logic       vendor_prot;
  } esa_sw_t;

  typedef struct packed {
    logic [7:0] slave_addr;
    logic [1:0] baud;
    logic       vendor_prot;
    logic [1:0] parity;
    logic       two_stop;
  } esa_line_cfg_t;

  typedef struct packed {
    esa_mode_t     mode;
    esa_sw_t       sw;
    logic [15:0]   offset;
    logic [15:0]   format;
    esa_line_cfg_t cfg;
    logic          online;
    logic          prog;
    logic          green;
    logic          yellow;
    logic [24:0]   flash_cnt;
    logic          flash_ph;
    logic [24:0]   act_cnt;
    logic [15:0]   rdata;
    logic          rvalid;
  } esa_state_t;

endpackage

// ===== tb/esa_config_props.sv
// Purpose: port assertions for esa_config
// Assumes: restart pulses at least 3 cycles apart
// Notes:   restart results land 2 edges after the restart edge
`timescale 1ns/1ps
module esa_config_props
  import esa_pkg::*;
(
  input wire logic          mclk,
  input wire logic          rstn,
  input wire esa_sw_t       sw,
  input wire logic          restart,
  input wire logic          var_rd,
  input wire logic          var_rvalid,
  input wire esa_line_cfg_t line_cfg,
  input wire logic          online,
  input wire logic          prog_mode,
  input wire logic          led_green
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  // =============================
  // properties
  property p_prog;
    prog_mode |-> line_cfg.slave_addr == ADDR_PROG && line_cfg.parity == PAR_NONE && line_cfg.two_stop;
  endproperty
  a_prog: assert property (p_prog) else $error("programming framing wrong");
  property p_hold;
    $past(rstn, 3) && !$past(restart) && !$past(restart, 2) && !$past(restart, 3) |-> $stable(line_cfg);
  endproperty
  a_hold: assert property (p_hold) else $error("line setup moved without restart");
  property p_drop;
    restart |=> !online;
  endproperty
  a_drop: assert property (p_drop) else $error("still online during restart");
  property p_baud;
    restart |-> ##2 line_cfg.baud == $past(sw.baud, 2) && line_cfg.vendor_prot == $past(sw.vendor_prot, 2);
  endproperty
  a_baud: assert property (p_baud) else $error("rate or protocol not latched");
  property p_direct;
    restart && !sw.ext && sw.addr != ADDR_SW_OFF |-> ##2 online && line_cfg.slave_addr == {4'h0, $past(sw.addr, 2)};
  endproperty
  a_direct: assert property (p_direct) else $error("direct address wrong");
  property p_enter;
    restart && !sw.ext && sw.addr == ADDR_SW_OFF |-> ##2 prog_mode && online;
  endproperty
  a_enter: assert property (p_enter) else $error("programming state not entered");
  property p_range;
    restart && sw.ext |-> ##2 !online || (line_cfg.slave_addr >= ADDR_EXT_MIN
      && line_cfg.slave_addr <= (line_cfg.vendor_prot ? ADDR_MAX_VENDOR : ADDR_MAX_MODBUS));
  endproperty
  a_range: assert property (p_range) else $error("extended address out of range");
  property p_noaddr;
    restart && sw.ext && sw.addr == ADDR_SW_OFF |-> ##2 !online && !prog_mode;
  endproperty
  a_noaddr: assert property (p_noaddr) else $error("online with no base address");
  property p_rvalid;
    var_rvalid == $past(var_rd);
  endproperty
  a_rvalid: assert property (p_rvalid) else $error("read valid misplaced");
  property p_green;
    !online && !$past(online) && !$past(online, 2) |-> led_green;
  endproperty
  a_green: assert property (p_green) else $error("green off while offline");
  cover property (restart && sw.ext ##2 online);
  cover property (prog_mode ##1 var_rvalid);
  cover property (online ##1 !led_green);
endmodule
bind esa_config esa_config_props i_esa_config_props (.mclk(mclk), .rstn(rstn), .sw(sw), .restart(restart),
  .var_rd(var_rd), .var_rvalid(var_rvalid), .line_cfg(line_cfg), .online(online), .prog_mode(prog_mode),
  .led_green(led_green));

// ===== tb/esa_master.sv
// Purpose: serial master model issuing variable accesses and frames
// Assumes: requests change at the falling edge
// Notes:   sends out-of-range values only when the bench asks
`timescale 1ns/1ps
module esa_master (
  input  wire logic        mclk,
  output logic             var_wr,
  output logic             var_rd,
  output logic [15:0]      var_index,
  output logic [15:0]      var_wdata,
  output logic             traffic,
  input  wire logic [15:0] var_rdata,
  input  wire logic        var_rvalid
);
  initial begin
    var_wr = 1'b0;
    var_rd = 1'b0;
    var_index = 16'h0000;
    var_wdata = 16'h0000;
    traffic = 1'b0;
  end
  task wr(input logic [15:0] idx, input logic [15:0] d);
    @(negedge mclk);
    var_index = idx;
    var_wdata = d;
    var_wr = 1'b1;
    @(negedge mclk);
    var_wr = 1'b0;
  endtask
  task rd(input logic [15:0] idx, output logic [15:0] d);
    @(negedge mclk);
    var_index = idx;
    var_rd = 1'b1;
    @(negedge mclk);
    var_rd = 1'b0;
    d = var_rvalid ? var_rdata : 16'hdead;
  endtask
  task frame;
    @(negedge mclk);
    traffic = 1'b1;
    @(negedge mclk);
    traffic = 1'b0;
  endtask
endmodule

// ===== tb/esa_config_tb.sv
// Purpose: directed bench for esa_config
// Assumes: short flash and activity counts
// Notes:   format 5 and offset 86 give address 87, 8E1
`timescale 1ns/1ps
module esa_config_tb;
  import esa_pkg::*;
  logic mclk = 0, rstn = 0, restart = 0, traffic, var_wr, var_rd, var_rvalid;
  logic online, prog_mode, led_green, led_yellow;
  logic [15:0] var_index, var_wdata, var_rdata, d;
  esa_sw_t sw = '0;
  esa_line_cfg_t line_cfg;
  int errors = 0, total_checks = 0, cyc = 0, n;
  always #20 mclk = ~mclk;
  esa_config #(.FLASH_CYC(8), .ACT_CYC(40)) i_esa_config (.mclk(mclk), .rstn(rstn), .sw(sw),
    .restart(restart), .traffic(traffic), .var_wr(var_wr), .var_rd(var_rd), .var_index(var_index),
    .var_wdata(var_wdata), .var_rdata(var_rdata), .var_rvalid(var_rvalid), .line_cfg(line_cfg),
    .online(online), .prog_mode(prog_mode), .led_green(led_green), .led_yellow(led_yellow));
  esa_master i_esa_master (.mclk(mclk), .var_wr(var_wr), .var_rd(var_rd), .var_index(var_index),
    .var_wdata(var_wdata), .traffic(traffic), .var_rdata(var_rdata), .var_rvalid(var_rvalid));
  task end_of_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      end_of_test();
    end
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  function logic [15:0] cfgv(input logic [7:0] a, input esa_sw_t s, input logic [2:0] f);
    return {2'h0, a, s.baud, s.vendor_prot, f[2:1], ~f[0]};
  endfunction
  task boot(input esa_sw_t s);
    @(negedge mclk);
    sw = s;
    restart = 1'b1;
    @(negedge mclk);
    restart = 1'b0;
    repeat (3) @(negedge mclk);
  endtask
  task cnt(input bit g);
    n = 0;
    repeat (40) begin
      @(negedge mclk);
      n += g ? led_green : led_yellow;
    end
  endtask
  initial begin
    repeat (2) @(negedge mclk);
    rstn = 1'b1;
    repeat (2) @(negedge mclk);
    chk(16'(line_cfg), cfgv(ADDR_PROG, '0, 3'h0));
    chk(16'({line_cfg.baud, line_cfg.vendor_prot}), 16'({BAUD_19K2, 1'b0}));
    cnt(1'b0);
    chk(16'(n > 0 && n < 40), 16'h0001);
    i_esa_master.rd(VAR_IDX_OFFSET, d);
    chk(d, OFFSET_RESET);
    i_esa_master.wr(VAR_IDX_OFFSET, 16'h0056);
    i_esa_master.wr(VAR_IDX_OFFSET, 16'h000e);
    i_esa_master.wr(VAR_IDX_OFFSET, 16'h00e9);
    i_esa_master.wr(VAR_IDX_FORMAT, 16'h0005);
    i_esa_master.wr(VAR_IDX_FORMAT, 16'h0006);
    i_esa_master.rd(VAR_IDX_OFFSET, d);
    chk(d, 16'h0056);
    i_esa_master.rd(VAR_IDX_FORMAT, d);
    chk(d, 16'h0005);
    sw = '{1'b1, 4'h1, 2'h0, 1'b0};
    repeat (5) @(negedge mclk);
    chk(16'(line_cfg), cfgv(ADDR_PROG, '0, 3'h0));
    boot(sw);
    chk(16'(line_cfg), cfgv(8'h57, sw, 3'h5));
    i_esa_master.frame();
    cnt(1'b1);
    chk(16'(n > 0 && n < 40), 16'h0001);
    repeat (60) @(negedge mclk);
    chk(16'(led_green), 16'h0001);
    boot('{1'b0, 4'h5, 2'h2, 1'b1});
    chk(16'(line_cfg), cfgv(8'h05, sw, 3'h5));
    i_esa_master.wr(VAR_IDX_OFFSET, 16'h00c1);
    i_esa_master.wr(VAR_IDX_OFFSET, 16'h00c0);
    i_esa_master.rd(VAR_IDX_OFFSET, d);
    chk(d, OFFSET_MAX_VENDOR);
    boot('{1'b1, 4'hf, 2'h0, 1'b1});
    chk(16'(line_cfg.slave_addr), 16'(ADDR_MAX_VENDOR));
    boot('{1'b1, 4'hf, 2'h0, 1'b0});
    chk(16'(line_cfg.slave_addr), 16'(ADDR_MAX_VENDOR));
    i_esa_master.wr(VAR_IDX_OFFSET, 16'h00e8);
    boot('{1'b1, 4'hf, 2'h0, 1'b0});
    chk(16'(line_cfg.slave_addr), 16'(ADDR_MAX_MODBUS));
    boot('{1'b1, 4'h0, 2'h0, 1'b0});
    chk(16'(online), 16'h0000);
    cnt(1'b0);
    chk(16'(n > 0 && n < 40), 16'h0001);
    boot('{1'b0, 4'h0, 2'h0, 1'b0});
    chk(16'(prog_mode), 16'h0001);
    i_esa_master.rd(VAR_IDX_OFFSET, d);
    chk(d, OFFSET_RESET);
    i_esa_master.rd(VAR_IDX_FORMAT, d);
    chk(d, FORMAT_RESET);
    rstn = 1'b0;
    repeat (2) @(negedge mclk);
    rstn = 1'b1;
    boot('{1'b1, 4'h1, 2'h0, 1'b0});
    chk(16'(online), 16'h0000);
    cnt(1'b0);
    chk(16'(n), 16'd40);
    chk(16'(led_green), 16'h0001);
    end_of_test();
  end
endmodule
